// ==== shared/dsc_defs.svh ====
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// clock rate and guard times
`define DSC_CLK_KHZ 125000
`define DSC_T6_MS 6000
`define DSC_T10_MS 10000
`define DSC_TONE_MS 250
`define DSC_T6_CYC (`DSC_T6_MS * `DSC_CLK_KHZ)
`define DSC_T10_CYC (`DSC_T10_MS * `DSC_CLK_KHZ)
`define DSC_TONE_CYC (`DSC_TONE_MS * `DSC_CLK_KHZ)

// digit codes from the tone decoder
`define DSC_CODE_ZERO 4'ha
`define DSC_CODE_STAR 4'hb
`define DSC_CODE_POUND 4'hc
`define DSC_NUM_TEN 4'ha

// multiple-port positions per shelf
`define DSC_MP_COUNT 10
`define DSC_MP_ALL 10'h3ff

// detection source bits and masks
`define DSC_SRC_TAB_IN_MASK 3'h2
`define DSC_SRC_ALL_MASK 3'h7

`endif

// ==== shared/dsc_pkg.sv ====
`include "dsc_defs.svh"

package dsc_pkg;

  // pins from the decoder and the option switches
  typedef struct packed {
    logic [2:0] stb;      // [0] splitter, [1] tab input, [2] tab output
    logic [3:0] code;
    logic [3:0] shelf_sw; // 1..10
    logic detect_route_switch;
    logic ack_route_switch;
  } dsc_pins_t;

  // selected target of a sequence
  typedef struct packed {
    logic common;
    logic [`DSC_MP_COUNT-1:0] mp;
  } dsc_target_t;

  // tone-coupling relay contacts
  typedef struct packed {
    logic tab_out;
    logic cp_comb;
    logic tab_in;
  } dsc_ack_t;

  typedef enum logic [1:0] {
    DSC_WAIT_SHELF,
    DSC_WAIT_SLOT,
    DSC_WAIT_CMD
  } dsc_state_t;

endpackage

// ==== src/dsc_sequence_ctrl.sv ====
`timescale 1ns/1ps
`include "dsc_defs.svh"

module dsc_sequence_ctrl
  import dsc_pkg::*;
#(
  parameter logic [31:0] T6_CYC = `DSC_T6_CYC,
  parameter logic [31:0] T10_CYC = `DSC_T10_CYC,
  parameter logic [31:0] TONE_CYC = `DSC_TONE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire dsc_pins_t pins,
  output logic relay_cp,
  output logic [`DSC_MP_COUNT-1:0] relay_mp,
  output logic tone_hi_on,
  output logic tone_lo_on,
  output dsc_ack_t ack_couple
);

  // digit value 1..10, or zero for star, pound and junk
  function automatic logic [3:0] dsc_num(input logic [3:0] code);
    logic [3:0] v;
    v = 4'h0;
    if (code == `DSC_CODE_ZERO) begin
      v = `DSC_NUM_TEN;
    end else if (code >= 4'h1 && code <= 4'h9) begin
      v = code;
    end
    return v;
  endfunction

  dsc_pins_t meta_reg, sync_reg;
  logic stb_prev_reg;
  dsc_state_t st_reg, st_next;
  logic en_reg, en_next;
  dsc_target_t tgt_reg, tgt_next;
  logic [31:0] t6_reg, t6_next, t10_reg, t10_next;
  logic [31:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
  logic cp_reg, cp_next;
  logic [`DSC_MP_COUNT-1:0] mp_reg, mp_next;
  logic hi_on_reg, hi_on_next, lo_on_reg, lo_on_next;
  dsc_ack_t ack_reg, ack_next;
  logic [2:0] src_mask;
  logic stb_now, dig_go, disc_go, conn_go, reject;
  logic [3:0] num;

  // two-flop synchroniser on every pin and switch
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      stb_prev_reg <= 1'b0;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      stb_prev_reg <= stb_now;
    end
  end

  assign src_mask = sync_reg.detect_route_switch ? `DSC_SRC_ALL_MASK : `DSC_SRC_TAB_IN_MASK;
  assign stb_now = |(sync_reg.stb & src_mask);
  // rising edge, one digit per strobe
  assign dig_go = stb_now & ~stb_prev_reg;
  assign num = dsc_num(sync_reg.code);

  // sequencing, timers, relays and tones
  always_comb begin
    st_next = st_reg;
    en_next = en_reg;
    tgt_next = tgt_reg;
    t6_next = t6_reg;
    t10_next = t10_reg;
    hi_cnt_next = hi_cnt_reg;
    lo_cnt_next = lo_cnt_reg;
    cp_next = cp_reg;
    mp_next = mp_reg;
    disc_go = 1'b0;
    conn_go = 1'b0;
    reject = 1'b0;
    if (t6_reg != 32'h0) begin
      t6_next = t6_reg - 32'h1;
    end
    if (t6_reg == 32'h1) begin
      en_next = 1'b0;
    end
    if (t10_reg != 32'h0) begin
      t10_next = t10_reg - 32'h1;
    end
    if (t10_reg == 32'h1) begin
      st_next = DSC_WAIT_SHELF;
      en_next = 1'b0;
    end
    if (hi_cnt_reg != 32'h0) begin
      hi_cnt_next = hi_cnt_reg - 32'h1;
    end
    if (lo_cnt_reg != 32'h0) begin
      lo_cnt_next = lo_cnt_reg - 32'h1;
    end
    if (dig_go) begin
      case (st_reg)
        DSC_WAIT_SHELF: begin
          st_next = DSC_WAIT_SLOT;
          en_next = (num != 4'h0) && (num == sync_reg.shelf_sw);
          t6_next = T6_CYC;
          t10_next = T10_CYC;
          tgt_next = '0;
        end
        DSC_WAIT_SLOT: begin
          st_next = DSC_WAIT_CMD;
          tgt_next = '0;
          if (num != 4'h0) begin
            tgt_next.mp = `DSC_MP_COUNT'(1) << (num - 4'h1);
          end else if (sync_reg.code == `DSC_CODE_STAR) begin
            tgt_next.mp = `DSC_MP_ALL;
          end else if (sync_reg.code == `DSC_CODE_POUND) begin
            tgt_next.common = 1'b1;
          end else begin
            en_next = 1'b0;
          end
        end
        default: begin
          // back to idle after third digit
          st_next = DSC_WAIT_SHELF;
          en_next = 1'b0;
          t6_next = 32'h0;
          t10_next = 32'h0;
          if (en_reg && t6_reg != 32'h0) begin
            disc_go = (sync_reg.code == `DSC_CODE_POUND);
            conn_go = (sync_reg.code == `DSC_CODE_STAR);
          end
        end
      endcase
    end
    if (disc_go) begin
      if (tgt_reg.common) begin
        cp_next = 1'b1;
        mp_next = '0;
        hi_cnt_next = TONE_CYC;
      end else if (cp_reg) begin
        reject = 1'b1;
      end else begin
        // already set bits stay, tone still sent
        mp_next = mp_reg | tgt_reg.mp;
        hi_cnt_next = TONE_CYC;
      end
    end
    if (conn_go) begin
      if (tgt_reg.common) begin
        cp_next = 1'b0;
      end else begin
        mp_next = mp_reg & ~tgt_reg.mp;
      end
      lo_cnt_next = TONE_CYC;
    end
    // tone enables, registered beside their timers
    hi_on_next = (hi_cnt_next != 32'h0);
    lo_on_next = (lo_cnt_next != 32'h0);
    // contacts follow the tone, routed by option
    ack_next.tab_out = (hi_cnt_next != 32'h0) || (lo_cnt_next != 32'h0);
    ack_next.cp_comb = ack_next.tab_out & sync_reg.ack_route_switch;
    ack_next.tab_in = ack_next.tab_out & sync_reg.ack_route_switch;
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= DSC_WAIT_SHELF;
      en_reg <= 1'b0;
      tgt_reg <= '0;
      t6_reg <= 32'h0;
      t10_reg <= 32'h0;
      hi_cnt_reg <= 32'h0;
      lo_cnt_reg <= 32'h0;
      cp_reg <= 1'b0;
      mp_reg <= '0;
      hi_on_reg <= 1'b0;
      lo_on_reg <= 1'b0;
      ack_reg <= '0;
    end else begin
      st_reg <= st_next;
      en_reg <= en_next;
      tgt_reg <= tgt_next;
      t6_reg <= t6_next;
      t10_reg <= t10_next;
      hi_cnt_reg <= hi_cnt_next;
      lo_cnt_reg <= lo_cnt_next;
      cp_reg <= cp_next;
      mp_reg <= mp_next;
      hi_on_reg <= hi_on_next;
      lo_on_reg <= lo_on_next;
      ack_reg <= ack_next;
    end
  end

  // outputs straight from flops
  assign relay_cp = cp_reg;
  assign relay_mp = mp_reg;
  assign tone_hi_on = hi_on_reg;
  assign tone_lo_on = lo_on_reg;
  assign ack_couple = ack_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence seq_hi_start;
    hi_on_reg && hi_cnt_reg == TONE_CYC;
  endsequence

  // high tone starts with a full quarter second
  tone_len_start_a: assert property ($rose(hi_on_reg) |-> seq_hi_start)
    else $error("high tone started without full duration");
  // low tone ends only when its timer runs out
  tone_len_end_a: assert property ($fell(lo_on_reg) |-> $past(lo_cnt_reg) == 32'h1)
    else $error("low tone ended early");
  // high tone ends only when its timer runs out
  hi_tone_end_a: assert property ($fell(hi_on_reg) |-> $past(hi_cnt_reg) == 32'h1)
    else $error("high tone ended early");
  // accepted disconnect plays the high tone
  disc_tone_a: assert property (disc_go && !reject |=> seq_hi_start)
    else $error("disconnect did not start high tone");
  conn_tone_a: assert property (conn_go |=> lo_on_reg && lo_cnt_reg == TONE_CYC)
    else $error("connect did not start low tone");
  // combiner and tab input only with option and tone
  ack_route_a: assert property (ack_reg.tab_in == ack_reg.cp_comb
    && ack_reg.cp_comb == (ack_reg.tab_out && $past(sync_reg.ack_route_switch)))
    else $error("ack routing inconsistent");
  reject_quiet_a: assert property (reject |=> $stable(mp_reg) && !$rose(hi_on_reg))
    else $error("rejected disconnect changed state");
  shelf_match_a: assert property (dig_go && st_reg == DSC_WAIT_SHELF
    && num != sync_reg.shelf_sw |=> !en_reg)
    else $error("foreign shelf enabled");
  common_disc_a: assert property (disc_go && tgt_reg.common |=> cp_reg && mp_reg == '0)
    else $error("common disconnect wrong");
  conn_clear_a: assert property (conn_go |=> (mp_reg & $past(tgt_reg.mp)) == '0)
    else $error("connect left relay energized");
  count_idle_a: assert property ((dig_go && st_reg == DSC_WAIT_CMD) || t10_reg == 32'h1
    |=> st_reg == DSC_WAIT_SHELF)
    else $error("digit counter not cleared");
  // tab output contact closed exactly while a tone plays
  couple_tone_a: assert property (ack_reg.tab_out == (hi_on_reg || lo_on_reg))
    else $error("coupling contacts out of step with tone");
  // numeric slot digit selects exactly one multiple port
  slot_pick_a: assert property (dig_go && st_reg == DSC_WAIT_SLOT && num != 4'h0
    |=> $onehot(tgt_reg.mp) && tgt_reg.mp[$past(num) - 4'h1] && !tgt_reg.common)
    else $error("numeric slot digit picked wrong module");
  // star slot digit selects every multiple port
  all_ports_a: assert property (dig_go && st_reg == DSC_WAIT_SLOT
    && sync_reg.code == `DSC_CODE_STAR |=> tgt_reg.mp == `DSC_MP_ALL && !tgt_reg.common)
    else $error("star slot digit missed some multiple ports");
  // pound slot digit selects the common port only
  common_pick_a: assert property (dig_go && st_reg == DSC_WAIT_SLOT
    && sync_reg.code == `DSC_CODE_POUND |=> tgt_reg.common && tgt_reg.mp == '0)
    else $error("pound slot digit did not pick the common port");
  // expired short timer blocks every command
  late_cmd_a: assert property (t6_reg == 32'h0 |-> !disc_go && !conn_go)
    else $error("command acted after the short timer ran out");
  // repeated disconnect keeps relays already energized
  keep_relay_a: assert property (disc_go && !tgt_reg.common && !cp_reg
    |=> (mp_reg & $past(mp_reg)) == $past(mp_reg) && hi_on_reg)
    else $error("repeated disconnect dropped a relay or its tone");
  // without the option only the tab input strobe counts
  detect_src_a: assert property (dig_go && !sync_reg.detect_route_switch
    |-> sync_reg.stb[1])
    else $error("digit taken from an unmonitored source");
  // one digit per strobe, never two in a row
  one_digit_a: assert property (dig_go |=> !dig_go)
    else $error("one strobe gave two digits");

endmodule

// ==== tb/dsc_decoder_model.sv ====
`timescale 1ns/1ps
module dsc_decoder_model (
  input wire logic mclk,
  output logic [2:0] stb,
  output logic [3:0] code
);
  // idle decoder, no digit held
  initial begin
    stb = 3'h0;
    code = 4'h5;
  end

  // digit held 4 cycles then a 4 cycle gap
  task automatic send(input logic [2:0] src, input logic [3:0] dig);
    @(posedge mclk);
    code <= dig;
    stb <= src;
    repeat (4) @(posedge mclk);
    stb <= 3'h0;
    // released code line shows the inverse, not the old digit
    code <= ~dig;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// ==== tb/dtmf_sequence_controller_tb_top.sv ====
`timescale 1ns/1ps
module dtmf_sequence_controller_tb_top;
  import dsc_pkg::*;
  localparam int TONE = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] shelf = 4'h5;
  logic det_all = 1'b0;
  logic ack_all = 1'b0;
  logic [2:0] stb;
  logic [3:0] code;
  dsc_pins_t pins;
  logic relay_cp;
  logic tone_hi_on;
  logic tone_lo_on;
  logic [9:0] relay_mp;
  dsc_ack_t ack_couple;
  int err_total = 0;
  int cmp_count = 0;
  int hi_len = 0;
  int lo_len = 0;
  int hi_cnt = 0;
  int lo_cnt = 0;

  // 125 MHz clock and pin bundle
  always #4 mclk = ~mclk;
  assign pins = {stb, code, shelf, det_all, ack_all};

  dsc_decoder_model i_dec (.mclk(mclk), .stb(stb), .code(code));

  // short timers keep the run brief, T6 below T10
  dsc_sequence_ctrl #(.T6_CYC(32'd200), .T10_CYC(32'd300), .TONE_CYC(32'd20)) i_dut (
    .mclk(mclk), .srst(srst), .pins(pins), .relay_cp(relay_cp), .relay_mp(relay_mp),
    .tone_hi_on(tone_hi_on), .tone_lo_on(tone_lo_on), .ack_couple(ack_couple));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // measure every tone pulse; contacts must be open while silent
  always @(negedge mclk) begin
    if (tone_hi_on === 1'b1) hi_len++;
    else if (hi_len > 0) begin
      chk(16'(hi_len), 16'(TONE));
      hi_cnt++;
      hi_len = 0;
    end
    if (tone_lo_on === 1'b1) lo_len++;
    else if (lo_len > 0) begin
      chk(16'(lo_len), 16'(TONE));
      lo_cnt++;
      lo_len = 0;
    end
    if (!srst && (tone_hi_on | tone_lo_on) !== 1'b1) chk(16'(ack_couple), 16'h0);
  end

  // one three-digit sequence, then relays and tones against expectation
  task automatic cmd(input logic [2:0] s, input logic [3:0] a, b, c, input logic ecp,
                     input logic [9:0] emp, input logic [1:0] et);
    int h0;
    int l0;
    h0 = hi_cnt;
    l0 = lo_cnt;
    i_dec.send(s, a);
    i_dec.send(s, b);
    i_dec.send(s, c);
    if (et != 2'h0) chk(16'(ack_couple), {13'h0, 1'b1, ack_all, ack_all});
    repeat (TONE + 8) @(posedge mclk);
    chk({5'h0, relay_cp, relay_mp}, {5'h0, ecp, emp});
    chk(16'(hi_cnt - h0), {15'h0, et == 2'h1});
    chk(16'(lo_cnt - l0), {15'h0, et == 2'h2});
  endtask

  task automatic t_slot();
    cmd(3'h2, 4'h5, 4'h3, 4'hc, 1'b0, 10'h004, 2'h1);
    cmd(3'h2, 4'h5, 4'h3, 4'hc, 1'b0, 10'h004, 2'h1);
    ack_all <= 1'b1;
    cmd(3'h2, 4'h5, 4'h3, 4'hb, 1'b0, 10'h000, 2'h2);
    cmd(3'h2, 4'h4, 4'h3, 4'hc, 1'b0, 10'h000, 2'h0);
    cmd(3'h2, 4'h5, 4'h3, 4'h5, 1'b0, 10'h000, 2'h0);
  endtask

  task automatic t_all();
    shelf <= 4'ha;
    cmd(3'h2, 4'ha, 4'hb, 4'hc, 1'b0, 10'h3ff, 2'h1);
    cmd(3'h2, 4'ha, 4'ha, 4'hb, 1'b0, 10'h1ff, 2'h2);
  endtask

  task automatic t_common();
    cmd(3'h2, 4'ha, 4'hc, 4'hc, 1'b1, 10'h000, 2'h1);
    cmd(3'h2, 4'ha, 4'h1, 4'hc, 1'b1, 10'h000, 2'h0);
    cmd(3'h2, 4'ha, 4'hc, 4'hb, 1'b0, 10'h000, 2'h2);
  endtask

  // late third digit does nothing; lone digit is flushed by the long timer
  task automatic t_timer();
    int h0;
    h0 = hi_cnt;
    i_dec.send(3'h2, 4'ha);
    i_dec.send(3'h2, 4'h1);
    repeat (200) @(posedge mclk);
    i_dec.send(3'h2, 4'hc);
    repeat (TONE + 8) @(posedge mclk);
    chk({5'h0, relay_cp, relay_mp}, 16'h0);
    chk(16'(hi_cnt - h0), 16'h0);
    i_dec.send(3'h2, 4'ha);
    // operator pause after a broken sequence
    repeat (310) @(posedge mclk);
    cmd(3'h2, 4'ha, 4'h1, 4'hc, 1'b0, 10'h001, 2'h1);
  endtask

  task automatic t_detect();
    cmd(3'h1, 4'ha, 4'h2, 4'hc, 1'b0, 10'h001, 2'h0);
    det_all <= 1'b1;
    cmd(3'h4, 4'ha, 4'h2, 4'hc, 1'b0, 10'h003, 2'h1);
    cmd(3'h1, 4'ha, 4'h1, 4'hb, 1'b0, 10'h002, 2'h2);
  endtask

  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    print_verdict();
  end

  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({relay_cp, relay_mp, tone_hi_on, tone_lo_on, ack_couple}, 16'h0);
    t_slot();
    t_all();
    t_common();
    t_timer();
    t_detect();
    print_verdict();
  end
endmodule
